//--- ptb_consts.svh
`ifndef PTB_CONSTS_SVH
`define PTB_CONSTS_SVH
// local register offsets, 1K control window
`define PTB_OFS_ID_STATUS  8'h00
`define PTB_OFS_FE_CFG     8'h10
`define PTB_OFS_FE_CTL     8'h20
`define PTB_OFS_FE_SEG     8'h30
`define PTB_OFS_SER_I2C    8'h40
`define PTB_OFS_GPIO       8'h50
`define PTB_OFS_STROBE_CONTROL    8'h60
`define PTB_OFS_STB_PRE    8'h70
`define PTB_OFS_HOLE       8'h80
`define PTB_OFS_STBA_START 8'h90
`define PTB_OFS_STBA_END   8'hA0
`define PTB_OFS_STBB_START 8'hB0
`define PTB_OFS_STBB_END   8'hC0
// identity_and_status fields
`define PTB_ID_POS         16
`define PTB_FLOW_EN_POS    8
`define PTB_RST_FLOW_EN    1'b1
`define PTB_RST_REG        32'h0000_0000
// buffers and timing
`define PTB_PW_DEPTH       7'h40
`define PTB_RD_DEPTH       16
`define PTB_RETRY_MAX      25'h100_0000
`define PTB_REPEAT_MAX     16'h8000
`define PTB_FLOW_IDLE      4'h7
`endif

//--- ptb_pkg.sv
package ptb_pkg;
	typedef enum logic [3:0] {
		ptb_io_rd  = 4'h2,
		ptb_io_wr  = 4'h3,
		ptb_mem_rd = 4'h6,
		ptb_mem_wr = 4'h7,
		ptb_cfg_rd = 4'hA,
		ptb_cfg_wr = 4'hB,
		ptb_mrm    = 4'hC,
		ptb_mrl    = 4'hE,
		ptb_mwi    = 4'hF
	} ptb_cmd_t;
	typedef enum logic [2:0] {
		ptb_r_none   = 3'h0,
		ptb_r_accept = 3'h1,
		ptb_r_retry  = 3'h2,
		ptb_r_disc   = 3'h3,
		ptb_r_tabort = 3'h4
	} ptb_resp_t;
	typedef enum logic [1:0] {
		ptb_m_normal = 2'h0,
		ptb_m_retry  = 2'h1,
		ptb_m_tabort = 2'h2,
		ptb_m_mabort = 2'h3
	} ptb_mstat_t;
	typedef enum logic [1:0] {
		ptb_ms_idle = 2'h0,
		ptb_ms_pw   = 2'h1,
		ptb_ms_dly  = 2'h2,
		ptb_ms_pf   = 2'h3
	} ptb_mst_state_t;
	typedef enum logic [1:0] {
		ptb_d_none = 2'h0,
		ptb_d_run  = 2'h1,
		ptb_d_hold = 2'h2
	} ptb_dly_state_t;
	typedef struct packed {
		ptb_cmd_t    cmd;
		logic [31:0] addr;
		logic [3:0]  be;
		logic [31:0] data;
		logic        last;
		logic        pref;
		logic        ctl_space;
		logic        dual_addr;
	} ptb_ini_phase_t;
	typedef struct packed {
		ptb_cmd_t    cmd;
		logic [31:0] addr;
		logic [3:0]  be;
		logic [31:0] data;
		logic        last;
	} ptb_mst_phase_t;
endpackage

//--- ptb_fifo.sv
`timescale 1ns/100ps
// depth must be a power of two
module ptb_fifo #(
	parameter int W = 32,
	parameter int D = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	input  wire logic         i_flush,
	// fill side
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	// drain side
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic [W-1:0]      o_data
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D + 1);
	logic [W-1:0]  mem_q [0:D-1];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic          push;
	logic          pop;
	assign o_ready = cnt_q != CW'(D);
	assign o_valid = cnt_q != '0;
	assign o_data  = mem_q[rd_q];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;
	always_ff @(posedge i_clk) begin
		if (push)
			mem_q[wr_q] <= i_data;
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (i_flush) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

//--- ptb_engine.sv
`timescale 1ns/100ps
`include "ptb_consts.svh"
module ptb_engine #(
	parameter logic [24:0] P_RETRY_MAX  = `PTB_RETRY_MAX,
	parameter logic [15:0] P_REPEAT_MAX = `PTB_REPEAT_MAX,
	parameter logic [7:0]  P_ID         = 8'h5A // arbitrary value
) (
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_resetn,
	// initiator side
	input  wire logic                    i_ini_valid,
	input  wire ptb_pkg::ptb_ini_phase_t i_ini_phase,
	output ptb_pkg::ptb_resp_t           o_ini_resp,
	output logic [31:0]                  o_ini_rdata,
	// configuration
	input  wire logic                    i_serr_en,
	input  wire logic [5:0]              i_cache_line_dw,
	// target-bus master
	output logic                         o_mst_valid,
	output ptb_pkg::ptb_mst_phase_t      o_mst_phase,
	input  wire logic                    i_mst_ack,
	input  wire ptb_pkg::ptb_mstat_t     i_mst_stat,
	input  wire logic [31:0]             i_mst_rdata,
	output logic                         o_serr,
	// secondary arbiter
	input  wire logic [2:0]              i_sec_req,
	input  wire logic                    i_sec_idle,
	output logic [2:0]                   o_sec_gnt
);
	import ptb_pkg::*;

	logic [35:0]    pw_mem_q [0:63];
	logic [31:0]    pw_addr_q;
	logic [6:0]     pw_wcnt_q;
	logic [6:0]     pw_rcnt_q;
	logic           pw_act_q;
	logic           pw_fill_q;
	logic [24:0]    pw_retry_q;
	ptb_dly_state_t dly_st_q;
	ptb_ini_phase_t dly_q;
	logic           dly_err_q;
	logic [31:0]    dly_rdata_q;
	logic           pf_act_q;
	logic           pf_fetch_q;
	logic           pf_flow_q;
	logic [31:0]    pf_faddr_q;
	logic [31:0]    pf_daddr_q;
	ptb_cmd_t       pf_cmd_q;
	logic [3:0]     pf_idle_q;
	logic [15:0]    tmo_q;
	ptb_mst_state_t ms_q;
	logic [31:0]    regs_q [1:12];
	logic           flow_en_q;
	logic [1:0]     last_q;

	ptb_resp_t      resp_d;
	logic [31:0]    rdata_d;
	logic           pw_push, pw_start, pw_endfill, dly_latch, dly_done;
	logic           pf_start, pf_pop, pf_last, rep_seen, reg_wr;
	logic           is_mw, is_pfr, is_reg, pf_hit, dly_hit, pw_disc;
	logic           ack_ok, ack_abt, pw_done, pw_abandon, pw_err;
	logic           tmo_hit, pf_end, rf_ready, rf_valid, rd_push;
	logic [31:0]    rf_data;
	logic [31:0]    status;

	function automatic logic same_req(ptb_ini_phase_t a, ptb_ini_phase_t b);
		return a.cmd == b.cmd && a.addr == b.addr && a.be == b.be &&
			(!a.cmd[0] || a.data == b.data);
	endfunction

	function automatic logic line_end(logic [31:0] a, logic [5:0] cl);
		return ((a[7:2] + 6'h01) & (cl - 6'h01)) == 6'h00;
	endfunction

	function automatic logic reg_ok(logic [31:0] a);
		return a[9:8] == 2'b00 && a[3:0] == 4'h0 &&
			a[7:0] <= `PTB_OFS_STBB_END && a[7:0] != `PTB_OFS_HOLE;
	endfunction

	function automatic logic [1:0] rr_pick(logic [2:0] req, logic [1:0] last);
		int j;
		rr_pick = last;
		for (int i = 3; i >= 1; i--) begin
			j = (int'(last) + i) % 3;
			if (req[j])
				rr_pick = 2'(j);
		end
	endfunction

	assign status = {8'h00, P_ID, 7'h00, flow_en_q, 4'h0,
		pf_flow_q, pf_act_q, dly_st_q != ptb_d_none, pw_act_q};

	// initiator phase decode
	always_comb begin
		ptb_cmd_t c;
		c          = i_ini_phase.cmd;
		resp_d     = ptb_r_none;
		rdata_d    = 32'h0000_0000;
		pw_push    = 1'b0;
		pw_start   = 1'b0;
		pw_endfill = 1'b0;
		dly_latch  = 1'b0;
		dly_done   = 1'b0;
		pf_start   = 1'b0;
		pf_pop     = 1'b0;
		pf_last    = 1'b0;
		rep_seen   = 1'b0;
		reg_wr     = 1'b0;
		is_mw      = c == ptb_mem_wr || c == ptb_mwi;
		is_pfr     = i_ini_phase.pref && !i_ini_phase.ctl_space &&
			(c == ptb_mem_rd || c == ptb_mrl || c == ptb_mrm);
		is_reg     = i_ini_phase.ctl_space && (c == ptb_mem_rd || is_mw);
		pf_hit     = pf_act_q && is_pfr && i_ini_phase.addr == pf_daddr_q;
		dly_hit    = dly_st_q == ptb_d_hold && same_req(i_ini_phase, dly_q);
		pw_disc    = pw_wcnt_q == `PTB_PW_DEPTH - 7'h01 ||
			(line_end(i_ini_phase.addr, i_cache_line_dw) &&
			(`PTB_PW_DEPTH - pw_wcnt_q - 7'h01) < {1'b0, i_cache_line_dw});
		if (i_ini_valid && !i_ini_phase.dual_addr) begin
			if (pw_fill_q) begin
				pw_push    = 1'b1;
				pw_endfill = i_ini_phase.last || pw_disc;
				resp_d     = pw_disc ? ptb_r_disc : ptb_r_accept;
			end else if (dly_hit) begin
				dly_done = 1'b1;
				rep_seen = 1'b1;
				rdata_d  = dly_rdata_q;
				resp_d   = dly_err_q ? ptb_r_tabort : ptb_r_accept;
			end else if (pw_act_q) begin
				resp_d = ptb_r_retry;
			end else if (is_reg) begin
				resp_d  = ptb_r_accept;
				reg_wr  = is_mw && reg_ok(i_ini_phase.addr);
				if (reg_ok(i_ini_phase.addr))
					rdata_d = i_ini_phase.addr[7:4] == 4'h0 ? status :
						regs_q[i_ini_phase.addr[7:4]];
			end else if (is_mw) begin
				pw_start   = 1'b1;
				pw_push    = 1'b1;
				pw_endfill = i_ini_phase.last || pw_disc;
				resp_d     = pw_disc ? ptb_r_disc : ptb_r_accept;
			end else if (pf_hit) begin
				rep_seen = 1'b1;
				if (rf_valid) begin
					pf_pop  = 1'b1;
					pf_last = i_ini_phase.last;
					rdata_d = rf_data;
					resp_d  = ptb_r_accept;
				end else begin
					resp_d = ptb_r_retry;
				end
			end else if (dly_st_q != ptb_d_none || pf_act_q) begin
				resp_d = ptb_r_retry;
			end else if (is_pfr) begin
				pf_start = 1'b1;
				resp_d   = ptb_r_retry;
			end else begin
				dly_latch = 1'b1;
				resp_d    = ptb_r_retry;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ini_resp  <= ptb_r_none;
			o_ini_rdata <= 32'h0000_0000;
		end else begin
			o_ini_resp  <= resp_d;
			o_ini_rdata <= rdata_d;
		end
	end

	// target-bus master phase; no dual-address form exists here
	assign ack_ok  = i_mst_ack && i_mst_stat == ptb_m_normal;
	assign ack_abt = i_mst_ack && (i_mst_stat == ptb_m_tabort || i_mst_stat == ptb_m_mabort);
	always_comb begin
		o_mst_valid = 1'b0;
		o_mst_phase = '0;
		case (ms_q)
			ptb_ms_pw: begin
				o_mst_valid       = pw_rcnt_q < pw_wcnt_q;
				o_mst_phase.cmd   = ptb_mem_wr;
				o_mst_phase.addr  = pw_addr_q + {23'h000000, pw_rcnt_q, 2'b00};
				o_mst_phase.be    = pw_mem_q[pw_rcnt_q[5:0]][35:32];
				o_mst_phase.data  = pw_mem_q[pw_rcnt_q[5:0]][31:0];
				o_mst_phase.last  = !pw_fill_q && pw_rcnt_q + 7'h01 == pw_wcnt_q;
			end
			ptb_ms_dly: begin
				o_mst_valid       = 1'b1;
				o_mst_phase.cmd   = dly_q.cmd;
				o_mst_phase.addr  = dly_q.addr;
				o_mst_phase.be    = dly_q.be;
				o_mst_phase.data  = dly_q.data;
				o_mst_phase.last  = 1'b1;
			end
			ptb_ms_pf: begin
				o_mst_valid       = pf_fetch_q && rf_ready;
				o_mst_phase.cmd   = pf_cmd_q;
				o_mst_phase.addr  = pf_faddr_q;
				o_mst_phase.be    = 4'hF;
				o_mst_phase.last  = pf_flow_q ? pf_faddr_q[11:2] == 10'h3FF :
					line_end(pf_faddr_q, i_cache_line_dw);
			end
			default: begin
				o_mst_valid = 1'b0;
			end
		endcase
	end

	assign pw_done    = ms_q == ptb_ms_pw && ack_ok && o_mst_phase.last;
	assign pw_err     = ms_q == ptb_ms_pw && i_mst_ack &&
		(i_mst_stat == ptb_m_tabort ||
		(i_mst_stat == ptb_m_retry && pw_retry_q == P_RETRY_MAX));
	assign pw_abandon = pw_err || (ms_q == ptb_ms_pw && i_mst_ack && i_mst_stat == ptb_m_mabort);

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ms_q <= ptb_ms_idle;
		end else begin
			case (ms_q)
				ptb_ms_idle: begin
					if (pw_act_q && (!pw_fill_q || pw_wcnt_q >= {1'b0, i_cache_line_dw}))
						ms_q <= ptb_ms_pw;
					else if (dly_st_q == ptb_d_run)
						ms_q <= ptb_ms_dly;
					else if (pf_fetch_q)
						ms_q <= ptb_ms_pf;
				end
				ptb_ms_pw: begin
					if (pw_done || pw_abandon)
						ms_q <= ptb_ms_idle;
				end
				ptb_ms_dly: begin
					if (i_mst_ack && i_mst_stat != ptb_m_retry)
						ms_q <= ptb_ms_idle;
				end
				ptb_ms_pf: begin
					if (!pf_fetch_q)
						ms_q <= ptb_ms_idle;
				end
				default: begin
					ms_q <= ptb_ms_idle;
				end
			endcase
		end
	end

	// posted write buffer
	always_ff @(posedge i_ref_clk) begin
		if (pw_push)
			pw_mem_q[pw_wcnt_q[5:0]] <= {i_ini_phase.be, i_ini_phase.data};
	end
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pw_act_q   <= 1'b0;
			pw_fill_q  <= 1'b0;
			pw_addr_q  <= 32'h0000_0000;
			pw_wcnt_q  <= 7'h00;
			pw_rcnt_q  <= 7'h00;
			pw_retry_q <= 25'h000_0000;
		end else if (pw_done || pw_abandon) begin
			pw_act_q   <= 1'b0;
			pw_fill_q  <= 1'b0;
			pw_wcnt_q  <= 7'h00;
			pw_rcnt_q  <= 7'h00;
			pw_retry_q <= 25'h000_0000;
		end else begin
			if (pw_start) begin
				pw_act_q  <= 1'b1;
				pw_fill_q <= 1'b1;
				pw_addr_q <= i_ini_phase.addr;
			end
			if (pw_push)
				pw_wcnt_q <= pw_wcnt_q + 7'h01;
			if (pw_endfill)
				pw_fill_q <= 1'b0;
			if (ms_q == ptb_ms_pw && ack_ok)
				pw_rcnt_q <= pw_rcnt_q + 7'h01;
			if (ms_q == ptb_ms_pw && i_mst_ack && i_mst_stat == ptb_m_retry)
				pw_retry_q <= pw_retry_q + 25'h000_0001;
		end
	end

	// delayed transaction
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dly_st_q    <= ptb_d_none;
			dly_q       <= '0;
			dly_err_q   <= 1'b0;
			dly_rdata_q <= 32'h0000_0000;
		end else begin
			case (dly_st_q)
				ptb_d_none: begin
					if (dly_latch) begin
						dly_q    <= i_ini_phase;
						dly_st_q <= ptb_d_run;
					end
				end
				ptb_d_run: begin
					if (ms_q == ptb_ms_dly && (ack_ok || ack_abt)) begin
						dly_rdata_q <= i_mst_rdata;
						dly_err_q   <= ack_abt;
						dly_st_q    <= ptb_d_hold;
					end
				end
				ptb_d_hold: begin
					if (dly_done || tmo_hit)
						dly_st_q <= ptb_d_none;
				end
				default: begin
					dly_st_q <= ptb_d_none;
				end
			endcase
		end
	end

	// repeat timeout for held results
	assign tmo_hit = (dly_st_q == ptb_d_hold || pf_act_q) && !rep_seen &&
		tmo_q == P_REPEAT_MAX - 16'h0001;
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn)
			tmo_q <= 16'h0000;
		else if ((dly_st_q == ptb_d_hold || pf_act_q) && !rep_seen && !tmo_hit)
			tmo_q <= tmo_q + 16'h0001;
		else
			tmo_q <= 16'h0000;
	end

	// prefetch and flow-through
	assign rd_push = ms_q == ptb_ms_pf && ack_ok;
	assign pf_end  = pf_act_q && (pf_last || (pf_act_q && tmo_hit) ||
		(!rf_valid && (!pf_fetch_q || (pf_flow_q && pf_idle_q == `PTB_FLOW_IDLE))));
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pf_act_q   <= 1'b0;
			pf_fetch_q <= 1'b0;
			pf_flow_q  <= 1'b0;
			pf_faddr_q <= 32'h0000_0000;
			pf_daddr_q <= 32'h0000_0000;
			pf_cmd_q   <= ptb_mem_rd;
			pf_idle_q  <= 4'h0;
		end else if (pf_end) begin
			pf_act_q   <= 1'b0;
			pf_fetch_q <= 1'b0;
			pf_flow_q  <= 1'b0;
			pf_idle_q  <= 4'h0;
		end else if (pf_start) begin
			pf_act_q   <= 1'b1;
			pf_fetch_q <= 1'b1;
			pf_flow_q  <= 1'b0;
			pf_faddr_q <= i_ini_phase.addr;
			pf_daddr_q <= i_ini_phase.addr;
			pf_cmd_q   <= i_ini_phase.cmd;
			pf_idle_q  <= 4'h0;
		end else begin
			if (rd_push)
				pf_faddr_q <= pf_faddr_q + 32'h0000_0004;
			if ((rd_push && o_mst_phase.last) || (ms_q == ptb_ms_pf && ack_abt))
				pf_fetch_q <= 1'b0;
			if (pf_pop)
				pf_daddr_q <= pf_daddr_q + 32'h0000_0004;
			if (pf_pop && pf_fetch_q && flow_en_q)
				pf_flow_q <= 1'b1;
			if (rf_valid)
				pf_idle_q <= 4'h0;
			else if (pf_idle_q != `PTB_FLOW_IDLE)
				pf_idle_q <= pf_idle_q + 4'h1;
		end
	end

	ptb_fifo #(
		.W(32),
		.D(`PTB_RD_DEPTH)
	) u_rd_fifo (
		.i_clk    (i_ref_clk),
		.i_resetn (i_resetn),
		.i_flush  (pf_end),
		.i_valid  (rd_push),
		.o_ready  (rf_ready),
		.i_data   (i_mst_rdata),
		.o_valid  (rf_valid),
		.i_ready  (pf_pop),
		.o_data   (rf_data)
	);

	// error pulse
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn)
			o_serr <= 1'b0;
		else
			o_serr <= i_serr_en && (pw_err ||
				(tmo_hit && dly_st_q == ptb_d_hold && dly_q.cmd[0]));
	end

	// local registers, byte-lane writes
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			flow_en_q <= `PTB_RST_FLOW_EN;
			for (int k = 1; k <= 12; k++)
				regs_q[k] <= `PTB_RST_REG;
		end else if (reg_wr) begin
			if (i_ini_phase.addr[7:4] == 4'h0) begin
				if (i_ini_phase.be[1])
					flow_en_q <= i_ini_phase.data[`PTB_FLOW_EN_POS];
			end else begin
				for (int b = 0; b < 4; b++)
					if (i_ini_phase.be[b])
						regs_q[i_ini_phase.addr[7:4]][8*b +: 8] <= i_ini_phase.data[8*b +: 8];
			end
		end
	end

	// secondary arbiter: index 0 processor, 1 mezzanine, 2 bridge
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			last_q    <= 2'h2;
			o_sec_gnt <= 3'h4;
		end else if (i_sec_idle && |i_sec_req) begin
			last_q    <= rr_pick(i_sec_req, last_q);
			o_sec_gnt <= 3'(3'h1 << rr_pick(i_sec_req, last_q));
		end
	end
endmodule

//--- ptb_engine_props.sv
`timescale 1ns/100ps
module ptb_engine_props (
	// clock and reset
	input wire logic                    i_ref_clk,
	input wire logic                    i_resetn,
	// initiator side
	input wire logic                    i_ini_valid,
	input wire ptb_pkg::ptb_ini_phase_t i_ini_phase,
	input wire ptb_pkg::ptb_resp_t      o_ini_resp,
	input wire logic                    i_serr_en,
	// target-bus master
	input wire logic                    o_mst_valid,
	input wire ptb_pkg::ptb_mst_phase_t o_mst_phase,
	input wire logic                    i_mst_ack,
	input wire logic                    o_serr,
	// secondary arbiter
	input wire logic [2:0]              i_sec_req,
	input wire logic                    i_sec_idle,
	input wire logic [2:0]              o_sec_gnt
);
	import ptb_pkg::*;
	logic [2:0] rr_next;
	// first requester after the current owner, owner itself last
	always_comb begin
		case (o_sec_gnt)
			3'h1: rr_next = i_sec_req[1] ? 3'h2 : (i_sec_req[2] ? 3'h4 : 3'h1);
			3'h2: rr_next = i_sec_req[2] ? 3'h4 : (i_sec_req[0] ? 3'h1 : 3'h2);
			default: rr_next = i_sec_req[0] ? 3'h1 : (i_sec_req[1] ? 3'h2 : 3'h4);
		endcase
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	a_gnt_onehot: assert property ($onehot(o_sec_gnt))
		else $error("grant not one-hot");
	a_gnt_rotate: assert property (i_sec_idle && i_sec_req != 3'h0 |=> o_sec_gnt == $past(rr_next))
		else $error("grant did not rotate");
	a_gnt_parked: assert property (i_sec_req == 3'h0 |=> $stable(o_sec_gnt))
		else $error("grant left parked owner");
	a_gnt_busy_hold: assert property (!i_sec_idle |=> $stable(o_sec_gnt))
		else $error("grant moved during busy bus");
	a_dual_ignored: assert property (i_ini_valid && i_ini_phase.dual_addr |=> o_ini_resp == ptb_r_none)
		else $error("dual address phase answered");
	a_resp_follows: assert property (o_ini_resp != ptb_r_none |-> $past(i_ini_valid))
		else $error("answer without a phase");
	a_mst_hold: assert property (o_mst_valid && !i_mst_ack |=> o_mst_valid && $stable(o_mst_phase))
		else $error("master phase changed before ack");
	a_no_mwi_out: assert property (o_mst_valid |-> o_mst_phase.cmd != ptb_mwi)
		else $error("invalidate command issued");
	a_serr_gated: assert property (o_serr |-> $past(i_serr_en))
		else $error("error pulse while disabled");
	a_serr_pulse: assert property (o_serr |=> !o_serr)
		else $error("error pulse too long");
endmodule

bind ptb_engine ptb_engine_props ptb_engine_props_i (.*);

//--- ptb_tgt_model.sv
`timescale 1ns/100ps
module ptb_tgt_model (
	// clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_resetn,
	// master phase from the bridge
	input  wire logic                    i_valid,
	input  wire ptb_pkg::ptb_mst_phase_t i_phase,
	// behaviour set by the bench
	input  wire logic [1:0]              i_wait,
	input  wire ptb_pkg::ptb_mstat_t     i_mode,
	// answer
	output logic                         o_ack,
	output ptb_pkg::ptb_mstat_t          o_stat,
	output logic [31:0]                  o_rdata
);
	import ptb_pkg::*;
	logic [1:0] cnt_q;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q <= 2'h0;
			o_ack <= 1'b0;
			o_stat <= ptb_m_normal;
			o_rdata <= 32'hFFFF_FFFF;
		end else begin
			o_ack <= 1'b0;
			// data line not driven: keeps toggling
			o_rdata <= ~o_rdata;
			if (i_valid && !o_ack) begin
				if (cnt_q >= i_wait) begin
					o_ack <= 1'b1;
					o_stat <= i_mode;
					o_rdata <= {i_phase.addr[15:0], ~i_phase.addr[15:0]};
					cnt_q <= 2'h0;
				end else begin
					cnt_q <= cnt_q + 2'h1;
				end
			end
		end
	end
endmodule

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
	import ptb_pkg::*;
	localparam logic [7:0] ID_VAL = 8'h3C; // arbitrary value
	logic           clk;
	logic           resetn;
	logic           ini_valid;
	ptb_ini_phase_t ini_ph;
	ptb_resp_t      ini_resp;
	logic [31:0]    ini_rdata;
	logic           serr_en;
	logic [5:0]     line_dw;
	logic           mst_valid;
	ptb_mst_phase_t mst_ph;
	logic           mst_ack;
	ptb_mstat_t     mst_stat;
	logic [31:0]    mst_rdata;
	logic           serr;
	logic [2:0]     sec_req;
	logic           sec_idle;
	logic [2:0]     sec_gnt;
	logic [1:0]     tgt_wait;
	ptb_mstat_t     tgt_mode;
	logic [15:0]    lfsr;
	int             n_fail;
	int             num_checks;
	int             n_serr;
	ptb_mst_phase_t mon_q[$];
	logic [31:0]    exp_q[$];
	ptb_cmd_t       dc[7] = '{ptb_io_wr, ptb_io_wr, ptb_io_wr, ptb_io_rd, ptb_io_rd, ptb_cfg_wr, ptb_cfg_rd};
	ptb_mstat_t     dm[7] = '{ptb_m_normal, ptb_m_tabort, ptb_m_mabort, ptb_m_normal, ptb_m_tabort,
		ptb_m_normal, ptb_m_normal};
	ptb_mstat_t     rm[3] = '{ptb_m_retry, ptb_m_tabort, ptb_m_mabort};
	ptb_cmd_t       pc[4] = '{ptb_mem_rd, ptb_mrl, ptb_mrm, ptb_mem_rd};

	ptb_engine #(.P_RETRY_MAX(25'h4), .P_REPEAT_MAX(16'h20), .P_ID(ID_VAL)) ptb_engine_i (
		.i_ref_clk(clk), .i_resetn(resetn), .i_ini_valid(ini_valid), .i_ini_phase(ini_ph),
		.o_ini_resp(ini_resp), .o_ini_rdata(ini_rdata), .i_serr_en(serr_en),
		.i_cache_line_dw(line_dw), .o_mst_valid(mst_valid), .o_mst_phase(mst_ph),
		.i_mst_ack(mst_ack), .i_mst_stat(mst_stat), .i_mst_rdata(mst_rdata), .o_serr(serr),
		.i_sec_req(sec_req), .i_sec_idle(sec_idle), .o_sec_gnt(sec_gnt)
	);
	ptb_tgt_model ptb_tgt_model_i (
		.i_clk(clk), .i_resetn(resetn), .i_valid(mst_valid), .i_phase(mst_ph), .i_wait(tgt_wait),
		.i_mode(tgt_mode), .o_ack(mst_ack), .o_stat(mst_stat), .o_rdata(mst_rdata)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// record every answered master phase and every error pulse
	always @(posedge clk) begin
		if (mst_valid && mst_ack) mon_q.push_back(mst_ph);
		if (serr) n_serr++;
	end

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return {lfsr, ~lfsr};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// f: {dual_addr, ctl_space, pref}
	task automatic set_ph(input ptb_cmd_t c, input logic [31:0] a, input logic [31:0] d,
		input logic l, input logic [2:0] f);
		ini_ph = '{c, a, 4'hF, d, l, f[0], f[1], f[2]};
		ini_valid = 1'b1;
	endtask
	task automatic single(input ptb_cmd_t c, input logic [31:0] a, input logic [31:0] d,
		input logic [2:0] f, input ptb_resp_t r);
		@(negedge clk);
		set_ph(c, a, d, 1'b1, f);
		@(negedge clk);
		ini_valid = 1'b0;
		check(ini_resp, r, "initiator answer");
	endtask
	task automatic wait_mon(input int n);
		int k;
		for (k = 0; k < 1000 && mon_q.size() < n; k++) @(negedge clk);
		repeat (3) @(negedge clk);
		check(mon_q.size(), n, "target transfer count");
	endtask
	task automatic dly(input ptb_cmd_t c, input logic [31:0] a, input logic [31:0] d,
		input ptb_mstat_t m, input ptb_resp_t r);
		tgt_mode = m;
		tgt_wait = 2'h3;
		mon_q.delete();
		single(c, a, d, 3'h0, ptb_r_retry);
		single(c, a, d, 3'h0, ptb_r_retry);
		wait_mon(1);
		check(mon_q[0].addr, a, "delayed address");
		if (c == ptb_io_wr || c == ptb_cfg_wr) check(mon_q[0].data, d, "delayed data");
		single(c, a, d, 3'h0, r);
		if (r == ptb_r_accept && (c == ptb_io_rd || c == ptb_cfg_rd))
			check(ini_rdata, {a[15:0], ~a[15:0]}, "delayed read data");
	endtask

	initial begin
		#100000;
		n_fail++;
		end_of_test();
	end

	initial begin
		int          i;
		int          k;
		int          j;
		logic [31:0] a;
		logic [31:0] d;
		logic [2:0]  e;
		lfsr = 16'h001F;
		{n_fail, num_checks, n_serr} = '0;
		ini_valid = 1'b0;
		ini_ph = '0;
		serr_en = 1'b1;
		line_dw = 6'h04;
		{sec_req, sec_idle} = 4'h0;
		tgt_wait = 2'h2;
		tgt_mode = ptb_m_normal;
		resetn = 1'b0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		check(sec_gnt, 3'h4, "grant parked after reset");
		single(ptb_mem_rd, 32'h0, 32'h0, 3'h4, ptb_r_none);
		// secondary arbiter, random requests and idle
		e = 3'h4;
		for (i = 0; i < 300; i++) begin
			@(negedge clk);
			check(sec_gnt, e, "secondary grant");
			d = rnd();
			sec_req = d[2:0];
			sec_idle = d[3];
			if (sec_idle && sec_req != 3'h0) begin
				k = (e == 3'h1) ? 0 : ((e == 3'h2) ? 1 : 2);
				for (j = 3; j > 0; j--)
					if (sec_req[(k + j) % 3]) e = 3'h1 << ((k + j) % 3);
			end
		end
		@(negedge clk);
		sec_req = 3'h0;
		// full posted burst, invalidate form
		line_dw = 6'h20;
		mon_q.delete();
		a = 32'h0000_4000;
		for (i = 0; i < 64; i++) begin
			@(negedge clk);
			if (i > 0) check(ini_resp, ptb_r_accept, "burst phase taken");
			check(mst_valid && i < 32, 1'b0, "target write began early");
			d = rnd();
			exp_q.push_back(d);
			set_ph(ptb_mwi, a + 4 * i, d, 1'b0, 3'h0);
		end
		@(negedge clk);
		ini_valid = 1'b0;
		check(ini_resp, ptb_r_disc, "full buffer disconnect");
		single(ptb_mem_rd, 32'h0, 32'h0, 3'h2, ptb_r_retry);
		wait_mon(64);
		check(mon_q[0].cmd, ptb_mem_wr, "write command");
		for (i = 0; i < 64; i++) begin
			check(mon_q[i].addr, a + 4 * i, "posted address");
			check(mon_q[i].data, exp_q[i], "posted data");
		end
		// local registers, unmapped places read zero
		single(ptb_mem_rd, 32'h0, 32'h0, 3'h2, ptb_r_accept);
		check(ini_rdata, {8'h00, ID_VAL, 16'h0100}, "status word");
		for (i = 0; i < 4; i++) begin
			d = rnd();
			a = (i == 0) ? 32'h10 : ((i == 1) ? 32'h80 : ((i == 2) ? 32'hC0 : 32'hD0));
			single(ptb_mem_wr, a, d, 3'h2, ptb_r_accept);
			single(ptb_mem_rd, a, 32'h0, 3'h2, ptb_r_accept);
			check(ini_rdata, (i[0] == 1'b0) ? d : 32'h0, "register readback");
		end
		// delayed transactions, normal, target-abort and master-abort outcomes
		for (i = 0; i < 7; i++)
			dly(dc[i], 32'h100 + 16 * i, rnd(), dm[i],
				(dm[i] == ptb_m_normal) ? ptb_r_accept : ptb_r_tabort);
		// unrepeated delayed write and read are dropped
		for (i = 0; i < 2; i++) begin
			a = 32'h200 + 16 * i;
			d = rnd();
			mon_q.delete();
			single((i == 0) ? ptb_io_wr : ptb_io_rd, a, d, 3'h0, ptb_r_retry);
			wait_mon(1);
			n_serr = 0;
			repeat (40) @(negedge clk);
			check(n_serr, (i == 0), "drop error pulse");
			dly((i == 0) ? ptb_io_wr : ptb_io_rd, a, d, ptb_m_normal, ptb_r_accept);
		end
		// posted write against retry, abort and missing target
		line_dw = 6'h04;
		tgt_wait = 2'h0;
		for (i = 0; i < 3; i++) begin
			serr_en = (i != 1);
			tgt_mode = rm[i];
			mon_q.delete();
			n_serr = 0;
			single(ptb_mem_wr, 32'h1000, rnd(), 3'h0, ptb_r_accept);
			repeat (60) @(negedge clk);
			check(mon_q.size(), (i == 0) ? 5 : 1, "posted attempts");
			check(n_serr, (i == 0), "posted error pulse");
		end
		// prefetchable reads stop at the line end, others are single
		serr_en = 1'b1;
		tgt_mode = ptb_m_normal;
		for (i = 0; i < 4; i++) begin
			a = 32'h2000 + 32'h40 * i;
			k = (i < 3) ? 4 : 1;
			mon_q.delete();
			single(pc[i], a, 32'h0, {2'h0, i < 3}, ptb_r_retry);
			repeat (30) @(negedge clk);
			check(mon_q.size(), k, "fetch length");
			check(mon_q[k - 1].addr, a + 4 * (k - 1), "fetch end address");
			check(mon_q[k - 1].last, 1'b1, "fetch ends on line");
			single(pc[i], a, 32'h0, {2'h0, i < 3}, ptb_r_accept);
			check(ini_rdata, {a[15:0], ~a[15:0]}, "fetched data");
		end
		end_of_test();
	end
endmodule
